//--- hdl/lvd_ctrl.sv
// Low-voltage detector control: registers, comparator sampling, reset and interrupt drive.
// Assumes an analog comparator output that is asynchronous to clk_i and a reset
// controller that tells whether the current reset was caused by this detector.
// The internal reset output is meant to come back as rst_i with own_reset_i high.
// Level changes while enabled are not blocked; software keeps the level steady.
//
// Behaviour
// - Any reset other than the detector's own clears the control register.
// - Detector's own reset keeps enable, source select and mode bits.
// - Control bit 7 enables detection; bits 6 to 3 read zero.
// - Control bit 2 picks supply rail (0) or external pin (1).
// - Interrupt mode: each crossing of threshold, either direction, raises an interrupt.
// - Reset mode: internal reset held while source below threshold.
// - Flag bit 0 reads 1 below threshold; 0 otherwise or when disabled.
// - Flag rises only after source stays below threshold 200 us.
// - Interrupt mode: clearing enable while below threshold raises interrupt.
// - Level field bits 3 to 0 pick sixteen thresholds, 0 highest.
// - Level register kept over own reset, cleared by other resets.
// - External source uses fixed reference; level field has no effect.
// - Pin direction bit 0: 0 output buffer on, 1 off.
// - Every reset sets pin direction register to all ones; bits 7-1 read one.
// - Pin direction register takes bit and byte writes.
// - Detector-caused reset sets bit 0 of reset cause register.
// - Any reset sets the detector interrupt mask flag.
`timescale 1ns/1ps
`default_nettype none

module lvd_ctrl #(
  parameter int BELOW_CYC = lvd_pkg::BELOW_MIN_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        own_reset_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        cmp_supply_below_i,
  input  wire logic        cmp_pin_below_i,
  output logic [7:0]       rdata_o,
  output logic [3:0]       threshold_code_o,
  output logic             comparator_on_o,
  output logic             source_select_o,
  output logic             internal_reset_o,
  output logic             detector_interrupt_o,
  output logic             shared_pin_oe_o
);

  // ****************************************
  // Register decode
  // ****************************************
  // Bus fields gathered in one struct so decode reads from one place
  lvd_pkg::lvd_bus_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  wire hit_ctrl  = (req.addr == lvd_pkg::ADDR_CTRL);
  wire hit_level = (req.addr == lvd_pkg::ADDR_LEVEL);
  wire hit_pin   = (req.addr == lvd_pkg::ADDR_PIN_DIR);
  wire hit_irq   = (req.addr == lvd_pkg::ADDR_IRQ_CTRL);
  wire hit_cause = (req.addr == lvd_pkg::ADDR_RESET_CAUSE);
  wire wr_ctrl   = req.wr && hit_ctrl;
  wire wr_level  = req.wr && hit_level;
  wire wr_pin    = req.wr && hit_pin;
  wire wr_irq    = req.wr && hit_irq;
  wire wr_cause  = req.wr && hit_cause;

  // ****************************************
  // Register state
  // ****************************************
  // Writes in the first cycle after release are dropped while state is restored
  logic       detector_enable;
  logic       source_select;
  logic       reset_or_irq_select;
  logic [3:0] level_code;
  logic       shared_pin_direction;
  logic       detector_irq_request;
  logic       detector_irq_mask;
  logic       detector_reset_cause;
  // High from reset until the first edge after release
  logic       reset_taken;

  // ****************************************
  // Comparator synchroniser
  // ****************************************
  // Three stages; a change counts once stages two and three agree
  // Both chains run all the time, so a source switch needs no restart
  // A source switch may show the old level until the new chain has settled
  logic [2:0] sync_supply;
  logic [2:0] sync_pin;
  logic       below_raw;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_supply <= 3'h0;
      sync_pin    <= 3'h0;
      below_raw   <= 1'b0;
    end
    else
    begin
      sync_supply <= {sync_supply[1:0], cmp_supply_below_i};
      sync_pin    <= {sync_pin[1:0], cmp_pin_below_i};
      if (source_select)
      begin
        if (sync_pin[1] == sync_pin[2])
          below_raw <= sync_pin[2];
      end
      else if (sync_supply[1] == sync_supply[2])
        below_raw <= sync_supply[2];
    end
  end

  // ****************************************
  // Qualification of the below state
  // ****************************************
  // Flag only rises after a sustained below state; it drops at once on recovery
  // Counter saturates at the threshold, so a long below state cannot wrap
  // Disabling clears the flag at once: a disabled detector reports no low state
  logic [lvd_pkg::BELOW_CNT_W-1:0] below_cnt;
  logic                            below_flag;
  wire  below_done = (below_cnt >= lvd_pkg::BELOW_CNT_W'(BELOW_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      below_cnt  <= '0;
      below_flag <= 1'b0;
    end
    else if (!detector_enable || !below_raw)
    begin
      below_cnt  <= '0;
      below_flag <= 1'b0;
    end
    else if (!below_done)
      below_cnt <= below_cnt + 1'b1;
    else
      below_flag <= 1'b1;
  end

  // ****************************************
  // Events
  // ****************************************
  logic flag_prev;
  // A drop forced by disabling is no crossing; the disable event reports it instead
  wire  flag_edge     = (below_flag != flag_prev) && detector_enable;
  wire  irq_mode      = !reset_or_irq_select;
  wire  next_en       = wr_ctrl ? req.wdata[lvd_pkg::CTRL_EN_BIT] : detector_enable;
  wire  disable_below = detector_enable && !next_en && below_flag;
  wire  irq_event     = irq_mode && (flag_edge || disable_below);
  wire  reset_want    = reset_or_irq_select && below_flag;

  // In reset mode the request is left alone; the reset itself reports the event
  // Previous flag starts at the flag's reset level, so no edge follows reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      flag_prev <= 1'b0;
    else
      flag_prev <= below_flag;
  end

  // ****************************************
  // Registers with reset-cause dependent retention
  // ****************************************
  // own_reset_i is sampled at the first edge after release; the reset itself only
  // loads constants, then the retained copies are restored or cleared.
  logic       keep_en;
  logic       keep_sel;
  logic       keep_mode;
  logic [3:0] keep_level;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      detector_enable      <= 1'b0;
      source_select        <= 1'b0;
      reset_or_irq_select  <= 1'b0;
      level_code           <= 4'h0;
      shared_pin_direction <= 1'b1;
      detector_irq_request <= 1'b0;
      detector_irq_mask    <= 1'b1;
      reset_taken          <= 1'b1;
    end
    else if (reset_taken)
    begin
      reset_taken <= 1'b0;
      if (own_reset_i)
      begin
        detector_enable     <= keep_en;
        source_select       <= keep_sel;
        reset_or_irq_select <= keep_mode;
        level_code          <= keep_level;
      end
    end
    else
    begin
      if (wr_ctrl)
      begin
        detector_enable     <= req.wdata[lvd_pkg::CTRL_EN_BIT];
        source_select       <= req.wdata[lvd_pkg::CTRL_SEL_BIT];
        reset_or_irq_select <= req.wdata[lvd_pkg::CTRL_MODE_BIT];
      end
      if (wr_level)
        level_code <= req.wdata[3:0];
      if (wr_pin)
        shared_pin_direction <= req.wdata[0];
      // Mask is held for software only; the interrupt output is not gated by it
      if (wr_irq)
        detector_irq_mask <= req.wdata[lvd_pkg::IRQ_MASK_BIT];
      // Hardware set wins over a software clear in the same cycle
      if (irq_event)
        detector_irq_request <= 1'b1;
      else if (wr_irq && !req.wdata[lvd_pkg::IRQ_REQ_BIT])
        detector_irq_request <= 1'b0;
    end
  end

  // Retained copies: cleared only by a non-own reset, tracked in normal running
  // No asynchronous reset, so the copies ride through the detector's own reset
  // A write in the last cycle before a reset is not retained
  always_ff @(posedge clk_i)
  begin
    if (reset_taken && !own_reset_i)
    begin
      keep_en    <= 1'b0;
      keep_sel   <= 1'b0;
      keep_mode  <= 1'b0;
      keep_level <= 4'h0;
    end
    else if (!reset_taken)
    begin
      keep_en    <= detector_enable;
      keep_sel   <= source_select;
      keep_mode  <= reset_or_irq_select;
      keep_level <= level_code;
    end
  end

  // Cause bit survives only its own reset; set while the detector holds reset
  // No asynchronous reset: the cause must outlive the reset it reports
  always_ff @(posedge clk_i)
  begin
    if (reset_taken)
      detector_reset_cause <= own_reset_i && detector_reset_cause;
    else if (reset_want)
      detector_reset_cause <= 1'b1;
    else if (wr_cause && !req.wdata[lvd_pkg::CAUSE_BIT])
      detector_reset_cause <= 1'b0;
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  // Unmapped addresses read zero; reads have no side effects
  wire [7:0] ctrl_view  = {detector_enable, 4'h0, source_select,
                           reset_or_irq_select, below_flag};
  wire [7:0] level_view = {4'h0, level_code};
  wire [7:0] pin_view   = lvd_pkg::PIN_DIR_FILL | {7'h00, shared_pin_direction};
  wire [7:0] irq_view   = {6'h00, detector_irq_mask, detector_irq_request};
  wire [7:0] cause_view = {7'h00, detector_reset_cause};
  wire [7:0] rd_mux     = hit_ctrl  ? ctrl_view  :
                          hit_level ? level_view :
                          hit_pin   ? pin_view   :
                          hit_irq   ? irq_view   :
                          hit_cause ? cause_view : 8'h00;

  // Every output registered, so the analog side and reset controller see clean levels
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o              <= 8'h00;
      threshold_code_o     <= 4'h0;
      comparator_on_o      <= 1'b0;
      source_select_o      <= 1'b0;
      internal_reset_o     <= 1'b0;
      detector_interrupt_o <= 1'b0;
      shared_pin_oe_o      <= 1'b0;
    end
    else
    begin
      rdata_o              <= req.rd ? rd_mux : 8'h00;
      threshold_code_o     <= level_code;
      comparator_on_o      <= detector_enable;
      source_select_o      <= source_select;
      internal_reset_o     <= reset_want;
      detector_interrupt_o <= irq_event;
      shared_pin_oe_o      <= !shared_pin_direction;
    end
  end

endmodule // lvd_ctrl

`default_nettype wire

//--- hdl/lvd_pkg.sv
// Package for the low-voltage detector control block: offsets, fields, reset values, timing.
// Assumes a 40 MHz system clock and a byte-wide register port.
package lvd_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] ADDR_PIN_DIR    = 16'hFF2C;
  localparam logic [15:0] ADDR_CTRL       = 16'hFFBE;
  localparam logic [15:0] ADDR_LEVEL      = 16'hFFBF;
  localparam logic [15:0] ADDR_IRQ_CTRL   = 16'hFFC0;
  localparam logic [15:0] ADDR_RESET_CAUSE = 16'hFFC1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_SEL_BIT  = 2;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;
  localparam int IRQ_REQ_BIT   = 0;
  localparam int IRQ_MASK_BIT  = 1;
  localparam int CAUSE_BIT     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] LEVEL_RESET   = 8'h00;
  localparam logic [7:0] PIN_DIR_RESET = 8'hFF;
  localparam logic [7:0] LEVEL_MASK    = 8'h0F;
  localparam logic [7:0] PIN_DIR_FILL  = 8'hFE;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 40_000_000;
  localparam int BELOW_MIN_US    = 200;
  localparam int BELOW_MIN_CYC   = (BELOW_MIN_US * (CLK_HZ / 1_000_000));
  localparam int BELOW_CNT_W     = 14;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } lvd_bus_req_t;

endpackage : lvd_pkg

//--- bench/lvd_ctrl_asserts.sv
// Port checker for the detector control block.
// Bound into every lvd_ctrl; sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl_asserts #(
  parameter int BELOW_CYC = 10
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        own_reset_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic        cmp_supply_below_i,
  input wire logic        cmp_pin_below_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [3:0]  threshold_code_o,
  input wire logic        comparator_on_o,
  input wire logic        source_select_o,
  input wire logic        internal_reset_o,
  input wire logic        detector_interrupt_o,
  input wire logic        shared_pin_oe_o
);
  wire logic sel_below = source_select_o ? cmp_pin_below_i : cmp_supply_below_i;
  wire logic rd_ctrl   = rd_i && (addr_i == lvd_pkg::ADDR_CTRL);
  wire logic rd_pin    = rd_i && (addr_i == lvd_pkg::ADDR_PIN_DIR);
  wire logic wr_ctrl   = wr_i && (addr_i == lvd_pkg::ADDR_CTRL);
  wire logic wr_level  = wr_i && (addr_i == lvd_pkg::ADDR_LEVEL);
  int        below_cnt;

  // Raw input count runs ahead of the synchronised one, so it is a safe lower bound
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) below_cnt <= 0;
    else below_cnt <= (sel_below && comparator_on_o) ? below_cnt + 1 : 0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ctrl_zero_bits: assert property ($past(rd_ctrl) |-> rdata_o[6:3] == 4'h0)
    else $error("control bits 6 to 3 not zero");
  a_pin_dir_ones: assert property ($past(rd_pin) |-> rdata_o[7:1] == 7'h7F)
    else $error("pin direction upper bits not one");
  a_oe_matches_dir: assert property ($past(rd_pin) |-> shared_pin_oe_o == !rdata_o[0])
    else $error("output enable disagrees with direction bit");
  a_flag_when_off: assert property ($past(rd_ctrl) && !rdata_o[7] |-> !rdata_o[0])
    else $error("flag set while detection disabled");
  // Written value reaches these outputs two edges after the strobe
  a_enable_written: assert property ($past(wr_ctrl, 2) |-> comparator_on_o == $past(wdata_i[7], 2))
    else $error("comparator enable not following write");
  a_source_written: assert property ($past(wr_ctrl, 2) |-> source_select_o == $past(wdata_i[2], 2))
    else $error("source select not following write");
  a_level_written: assert property ($past(wr_level, 2) |-> threshold_code_o == $past(wdata_i[3:0], 2))
    else $error("threshold code not following write");
  a_irq_one_cycle: assert property (detector_interrupt_o |=> !detector_interrupt_o)
    else $error("interrupt longer than one cycle");
  a_below_min_time: assert property ($rose(internal_reset_o) |-> below_cnt >= BELOW_CYC)
    else $error("internal reset before minimum below time");
  a_reset_release: assert property ($fell(sel_below) && internal_reset_o |-> ##[1:8] !internal_reset_o)
    else $error("internal reset not released on recovery");

  c_irq: cover property (detector_interrupt_o);
  c_reset: cover property ($rose(internal_reset_o));
  c_flag_read: cover property ($past(rd_ctrl) && rdata_o[0]);
endmodule // lvd_ctrl_asserts
bind lvd_ctrl lvd_ctrl_asserts #(.BELOW_CYC(BELOW_CYC)) u_chk (.*);
`default_nettype wire

//--- bench/lvd_cmp_model.sv
// Comparator stand-in for the detector block's analog side.
// Supply is a step index: step k sits at threshold k, 0 the highest.
`timescale 1ns/1ps
`default_nettype none
module lvd_cmp_model (
  input  wire logic       on_i,
  input  wire logic [3:0] code_i,
  input  wire logic [4:0] supply_step_i,
  input  wire logic       pin_low_i,
  output logic            supply_below_o,
  output logic            pin_below_o
);
  // Unpowered comparator claims below, so the block must mask it
  assign supply_below_o = !on_i || (supply_step_i > {1'b0, code_i});
  assign pin_below_o    = !on_i || pin_low_i;
endmodule // lvd_cmp_model
`default_nettype wire

//--- bench/lvd_ctrl_bench.sv
// Self-checking bench for the detector control block.
// Drives the register port, comparator model and resets; no other parts.
`timescale 1ns/1ps
`default_nettype none
module lvd_ctrl_bench;
  localparam int BC  = 10;
  localparam int LAT = BC + 8;
  logic        clk_i = 0, rst_i = 1, own_reset_i = 0, wr_i = 0, rd_i = 0, pin_low = 0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0]  wdata_i = 8'h00, rdata_o, got;
  logic [4:0]  sup = 5'h00;
  logic [3:0]  code;
  logic        on, sel, ireset, irq, oe, csb, cpb;
  int          bad_count = 0, n_tests = 0, irqs = 0, cyc = 0;

  lvd_ctrl #(.BELOW_CYC(BC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .own_reset_i(own_reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .cmp_supply_below_i(csb),
    .cmp_pin_below_i(cpb), .rdata_o(rdata_o), .threshold_code_o(code), .comparator_on_o(on),
    .source_select_o(sel), .internal_reset_o(ireset), .detector_interrupt_o(irq), .shared_pin_oe_o(oe));
  lvd_cmp_model u_cmp (.on_i(on), .code_i(code), .supply_step_i(sup), .pin_low_i(pin_low),
    .supply_below_o(csb), .pin_below_o(cpb));

  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
    chk(nm, e, got);
  endtask
  task automatic do_reset(input logic own);
    @(posedge clk_i);
    rst_i <= 1'b1;
    own_reset_i <= own;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wait_lat();
    repeat (LAT) @(posedge clk_i);
    #1;
  endtask
  // Comparator needs its settling time before any result counts
  task automatic ctl_on(input logic [7:0] d);
    wr(16'hFFBE, d);
    repeat (400) @(posedge clk_i);
    #1 irqs = 0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_vals();
    rchk("ctrl", 16'hFFBE, 8'h00);
    rchk("level", 16'hFFBF, 8'h00);
    rchk("pin_dir", 16'hFF2C, 8'hFF);
    rchk("irq_ctrl", 16'hFFC0, 8'h02);
    rchk("unmapped", 16'h0000, 8'h00);
  endtask
  task automatic t_regs();
    wr(16'hFFBF, 8'h0F);
    rchk("level", 16'hFFBF, 8'h0F);
    chk("code", 8'h0F, {4'h0, code});
    wr(16'hFF2C, 8'hFE);
    rchk("pin_dir", 16'hFF2C, 8'hFE);
    chk("oe", 8'h01, {7'h00, oe});
    wr(16'hFF2C, 8'hFF);
    @(posedge clk_i);
    #1 chk("oe", 8'h00, {7'h00, oe});
  endtask
  task automatic t_irq();
    wr(16'hFFBF, 8'h03);
    ctl_on(8'h80);
    chk("comp_on", 8'h01, {7'h00, on});
    sup <= 5'h05;
    wait_lat();
    chk("irq_fall", 8'h01, irqs[7:0]);
    rchk("ctrl", 16'hFFBE, 8'h81);
    sup <= 5'h00;
    wait_lat();
    chk("irq_rise", 8'h02, irqs[7:0]);
    rchk("ctrl", 16'hFFBE, 8'h80);
    sup <= 5'h05;
    wait_lat();
    wr(16'hFFC0, 8'h02);
    rchk("irq_clear", 16'hFFC0, 8'h02);
    irqs = 0;
    wr(16'hFFBE, 8'h00);
    wait_lat();
    chk("irq_stop", 8'h01, irqs[7:0]);
    rchk("irq_ctrl", 16'hFFC0, 8'h03);
    rchk("ctrl", 16'hFFBE, 8'h00);
    sup <= 5'h00;
  endtask
  // Supply sits below the level, yet only the pin may count
  task automatic t_pin();
    wr(16'hFFBF, 8'h00);
    sup <= 5'h03;
    ctl_on(8'h84);
    chk("src_sel", 8'h01, {7'h00, sel});
    wait_lat();
    rchk("ctrl", 16'hFFBE, 8'h84);
    pin_low <= 1'b1;
    wait_lat();
    rchk("ctrl", 16'hFFBE, 8'h85);
    pin_low <= 1'b0;
    sup <= 5'h00;
    wr(16'hFFBE, 8'h00);
  endtask
  task automatic t_reset_mode();
    wr(16'hFFBF, 8'h02);
    ctl_on(8'h80);
    wr(16'hFFBE, 8'h82);
    sup <= 5'h06;
    wait_lat();
    chk("int_reset", 8'h01, {7'h00, ireset});
    sup <= 5'h00;
    repeat (8) @(posedge clk_i);
    #1 chk("int_reset", 8'h00, {7'h00, ireset});
    wr(16'hFF2C, 8'hFE);
    sup <= 5'h06;
    wait_lat();
    do_reset(1'b1);
    rchk("ctrl", 16'hFFBE, 8'h82);
    rchk("level", 16'hFFBF, 8'h02);
    rchk("cause", 16'hFFC1, 8'h01);
    rchk("pin_dir", 16'hFF2C, 8'hFF);
    rchk("irq_ctrl", 16'hFFC0, 8'h02);
    sup <= 5'h00;
    do_reset(1'b0);
    rchk("ctrl", 16'hFFBE, 8'h00);
    rchk("level", 16'hFFBF, 8'h00);
  endtask

  initial
  begin
    do_reset(1'b0);
    t_reset_vals();
    t_regs();
    t_irq();
    t_pin();
    t_reset_mode();
    report_and_stop();
  end
endmodule // lvd_ctrl_bench
`default_nettype wire
